// ---- include/ics_link_if.sv ----
`timescale 1ns/1ps
interface ics_link_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // open-drain wire with pull-up
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport device (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input  sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface : ics_link_if

// ---- include/ics_pkg.sv ----
// What this block does
// [R1] address byte bit 0: 1 read, 0 write
// [R2] own address 0x70 plus strap value
// [R3] acknowledge matching address in ninth clock
// [R4] written bytes go straight to register
// [R5] any byte count; last byte kept
// [R6] read sends register, msb first
// [R7] controller acks more, nacks last, stops
// [R8] after controller nack, release data line
// [R9] register bit n enables channel n
// [R10] any channel combination allowed
// [R11] new selection applied only at stop
// [R12] controller stops right after write ack
// [R13] register and enables zero after reset
// [R14] reset pin low clears everything
// [R15] power-on hold clears until threshold reached
// [R16] write: start, address+0, ack, data, stop
// [R17] serial clock up to 400 kHz
// [R18] continued read repeats register value
// [R19] deselection also applied at stop
package ics_pkg;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS   = 2500;
  localparam int QUARTER_CYC     = (SCL_PERIOD_NS + 4 * CLOCK_PERIOD_NS - 1) / (4 * CLOCK_PERIOD_NS);
  localparam int RESET_LOW_NS    = 6;
  localparam int RESET_LOW_CYC   = (RESET_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  localparam logic [6:0] BASE_ADDR      = 7'h70;
  localparam logic [7:0] CHAN_SEL_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

  localparam logic [7:0] REG_TARGET = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_CMD    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RXDATA = 8'h10;

  localparam int CMD_GO_BIT     = 0;
  localparam int CMD_READ_BIT   = 1;
  localparam int CMD_COUNT_LSB  = 4;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_NACK_BIT  = 1;

  typedef enum logic [2:0] {
    D_IDLE     = 3'b000,
    D_ADDR     = 3'b001,
    D_ACK_ADDR = 3'b010,
    D_WRITE    = 3'b011,
    D_ACK_WR   = 3'b100,
    D_READ     = 3'b101,
    D_ACK_RD   = 3'b110
  } ics_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BYTE  = 2'b10,
    H_STOP  = 2'b11
  } ics_host_state_t;
endpackage : ics_pkg

// ---- sim/ics_link_monitor.sv ----
`timescale 1ns/1ps
module ics_link_monitor (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       dev_sda_oe,
  input wire logic       addr_sel_0,
  input wire logic       addr_sel_1,
  input wire logic       addr_sel_2,
  input wire logic [7:0] chan_enable,
  input wire logic [7:0] chan_select
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bitc;
  logic [7:0] sr;
  logic       first;
  logic       rd;
  logic       hit;
  logic       released;
  logic [9:0] per_cnt;
  logic [9:0] stop_cnt;
  logic       start_c;
  logic       stop_c;
  logic       rise;
  logic [6:0] own;

  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c  = scl && scl_q && !sda_q && sda;
  assign rise    = scl && !scl_q;
  assign own     = 7'h70 + {4'h0, addr_sel_2, addr_sel_1, addr_sel_0};

  always_ff @(posedge clock)
  begin
    scl_q <= sys_rst ? 1'b1 : scl;
    sda_q <= sys_rst ? 1'b1 : sda;
  end

  // frame decoder: bit slot, direction and address hit
  always_ff @(posedge clock)
  begin
    if (sys_rst || start_c)
    begin
      bitc     <= 4'h0;
      first    <= !sys_rst;
      rd       <= 1'b0;
      hit      <= 1'b0;
      released <= 1'b0;
    end
    else if (rise)
    begin
      sr       <= {sr[6:0], sda};
      bitc     <= (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
      first    <= first && bitc != 4'h8;
      rd       <= (first && bitc == 4'h7) ? sda : rd;
      hit      <= (first && bitc == 4'h8) ? sr[7:1] == own : hit;
      released <= released || (rd && hit && !first && bitc == 4'h8 && sda);
    end
  end

  // cycles since the last clock rise and since the last stop
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      per_cnt  <= 10'h3FF;
      stop_cnt <= 10'h3FF;
    end
    else
    begin
      per_cnt  <= rise ? 10'h001 : per_cnt + {9'h000, per_cnt != 10'h3FF};
      stop_cnt <= stop_c ? 10'h000 : stop_cnt + {9'h000, stop_cnt != 10'h3FF};
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  scl_period_a: assert property (rise |-> per_cnt >= 10'h0FA)
    else $error("serial clock period below 2500 ns");
  addr_ack_a: assert property (rise && first && bitc == 4'h8 && sr[7:1] == own |-> !sda && dev_sda_oe)
    else $error("own address not acknowledged");
  other_addr_a: assert property (rise && first && bitc == 4'h8 && sr[7:1] != own |-> !dev_sda_oe)
    else $error("foreign address acknowledged");
  write_store_a: assert property (
    rise && !first && hit && !rd && bitc == 4'h8 |-> dev_sda_oe && chan_select == sr)
    else $error("write byte not acked or not stored");
  read_data_a: assert property (
    rise && !first && hit && rd && !released && bitc < 4'h8 |-> sda == chan_select[3'h7 - bitc[2:0]])
    else $error("read bit differs from register");
  nack_release_a: assert property (released |-> !dev_sda_oe)
    else $error("data line driven after nack");
  low_scl_change_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  enable_at_stop_a: assert property (
    $changed(chan_enable) && chan_enable != 8'h00 |-> stop_cnt < 10'h010)
    else $error("enables changed away from stop");
  enable_copy_a: assert property (stop_cnt == 10'h010 |-> chan_enable == chan_select)
    else $error("enables differ from register after stop");

  cover property (rise && rd && hit && !first && bitc == 4'h8 && !sda);
  cover property (rise && !rd && hit && !first && bitc == 4'h8);
  cover property (rise && first && bitc == 4'h8 && sr[7:1] != own);
endmodule : ics_link_monitor

// ---- sim/ics_switch_ctrl_tb.sv ----
`timescale 1ns/1ps
module ics_switch_ctrl_tb;
  localparam logic [7:0] PATS [8] = '{8'h01, 8'h80, 8'hFF, 8'h00, 8'h5A, 8'hA5, 8'h3C, 8'hC3};
  logic        clock               = 1'b0;
  logic        sys_rst             = 1'b1;
  logic        reset_pin_n         = 1'b1;
  logic        por_below_threshold = 1'b0;
  logic [2:0]  straps              = 3'h0;
  logic [7:0]  reg_addr            = 8'h00;
  logic [31:0] reg_wdata           = 32'h00000000;
  logic        reg_wr              = 1'b0;
  logic        reg_rd              = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  chan_enable;
  logic [7:0]  chan_select;
  logic [31:0] st;
  int          err_count           = 0;
  int          n_tests             = 0;

  always #5 clock = ~clock;

  ics_link_if ics_link_if_inst ();
  ics_switch_dev ics_switch_dev_inst (.clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .por_below_threshold(por_below_threshold), .addr_sel_0(straps[0]), .addr_sel_1(straps[1]),
    .addr_sel_2(straps[2]), .link(ics_link_if_inst.device), .chan_enable(chan_enable), .chan_select(chan_select));
  ics_ctrl_host ics_ctrl_host_inst (.clock(clock), .sys_rst(sys_rst), .link(ics_link_if_inst.host),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ics_link_monitor ics_link_monitor_inst (.clock(clock), .sys_rst(sys_rst), .scl(ics_link_if_inst.scl),
    .sda(ics_link_if_inst.sda), .dev_sda_oe(ics_link_if_inst.dev_sda_oe), .addr_sel_0(straps[0]),
    .addr_sel_1(straps[1]), .addr_sel_2(straps[2]), .chan_enable(chan_enable), .chan_select(chan_select));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // poll status until the transfer is over, then let the stop reach the enables
  task automatic wait_idle();
    st = 32'h00000001;
    for (int k = 0; k < 8000 && st[ics_pkg::STAT_BUSY_BIT] !== 1'b0; k++)
      reg_read(ics_pkg::REG_STATUS, st);
    if (st[ics_pkg::STAT_BUSY_BIT] !== 1'b0)
      err_count++;
    repeat (8) @(posedge clock);
  endtask : wait_idle

  task automatic start_xfer(input logic [6:0] tgt, input logic rdn, input logic [2:0] cnt_m1, input logic [7:0] tx);
    reg_write(ics_pkg::REG_TXDATA, {24'h000000, tx});
    reg_write(ics_pkg::REG_TARGET, {25'h0000000, tgt});
    reg_write(ics_pkg::REG_CMD, {25'h0000000, cnt_m1, 2'b00, rdn, 1'b1});
  endtask : start_xfer

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (95000) @(posedge clock);
    err_count++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check("sel_reset", {24'h000000, chan_select}, 32'h00000000);
    check("en_reset", {24'h000000, chan_enable}, 32'h00000000);
    reg_read(8'hFC, st);
    check("unmapped", st, 32'h00000000);
    // every strap setting, channel patterns including none and all
    for (int i = 0; i < 8; i++)
    begin
      straps <= i[2:0];
      repeat (4) @(posedge clock);
      start_xfer(7'h70 + {4'h0, i[2:0]}, 1'b0, 3'h0, PATS[i]);
      wait_idle();
      check("status_w", st, 32'h00000000);
      check("sel_w", {24'h000000, chan_select}, {24'h000000, PATS[i]});
      check("en_w", {24'h000000, chan_enable}, {24'h000000, PATS[i]});
    end
    start_xfer(7'h76, 1'b0, 3'h0, 8'h11);
    wait_idle();
    check("status_other", st, 32'h00000002);
    check("sel_other", {24'h000000, chan_select}, 32'h000000C3);
    // three bytes, data changed after the first; enables hold the old set until the stop
    start_xfer(7'h77, 1'b0, 3'h2, 8'h3C);
    for (int k = 0; k < 8000 && chan_select !== 8'h3C; k++)
      @(posedge clock);
    check("sel_first", {24'h000000, chan_select}, 32'h0000003C);
    reg_write(ics_pkg::REG_TXDATA, 32'h0000000F);
    check("en_hold", {24'h000000, chan_enable}, 32'h000000C3);
    wait_idle();
    check("status_multi", st, 32'h00000000);
    check("sel_multi", {24'h000000, chan_select}, 32'h0000000F);
    check("en_multi", {24'h000000, chan_enable}, 32'h0000000F);
    for (int n = 0; n < 3; n += 2)
    begin
      start_xfer(7'h77, 1'b1, n[2:0], 8'h00);
      wait_idle();
      check("status_r", st, 32'h00000000);
      reg_read(ics_pkg::REG_RXDATA, st);
      check("rxdata", st, 32'h0000000F);
      check("sel_r", {24'h000000, chan_select}, 32'h0000000F);
    end
    reset_pin_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_pin_n <= 1'b1;
    repeat (8) @(posedge clock);
    check("sel_pin", {24'h000000, chan_select}, 32'h00000000);
    check("en_pin", {24'h000000, chan_enable}, 32'h00000000);
    start_xfer(7'h77, 1'b0, 3'h0, 8'h81);
    wait_idle();
    check("en_again", {24'h000000, chan_enable}, 32'h00000081);
    por_below_threshold <= 1'b1;
    repeat (4) @(posedge clock);
    por_below_threshold <= 1'b0;
    repeat (8) @(posedge clock);
    check("sel_por", {24'h000000, chan_select}, 32'h00000000);
    check("en_por", {24'h000000, chan_enable}, 32'h00000000);
    summarize();
  end
endmodule : ics_switch_ctrl_tb

// ---- verilog/ics_ctrl_host.sv ----
`timescale 1ns/1ps
module ics_ctrl_host (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  ics_link_if.host         link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);
  logic [1:0]               sda_sy;
  logic [6:0]               target;
  logic [7:0]               txdata;
  logic [7:0]               rxdata;
  logic                     nack;
  ics_pkg::ics_host_state_t state;
  logic [6:0]               qcnt;
  logic                     tick;
  logic [1:0]               phase;
  logic [3:0]               slot;
  logic [7:0]               txsh;
  logic [7:0]               rxsh;
  logic                     rw;
  logic                     recv;
  logic                     addr_phase;
  logic [2:0]               left;
  logic                     scl_rel;
  logic                     sda_rel;
  logic                     go;

  assign go   = reg_wr && reg_addr == ics_pkg::REG_CMD && reg_wdata[ics_pkg::CMD_GO_BIT]
                && state == ics_pkg::H_IDLE;
  assign tick = qcnt == 7'(ics_pkg::QUARTER_CYC - 1);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sda_sy <= 2'h3;
    end
    else
    begin
      sda_sy <= {sda_sy[0], link.sda};
    end
  end

  // software registers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      target <= 7'h00;
      txdata <= 8'h00;
    end
    else if (reg_wr && reg_addr == ics_pkg::REG_TARGET)
    begin
      target <= reg_wdata[6:0];
    end
    else if (reg_wr && reg_addr == ics_pkg::REG_TXDATA)
    begin
      txdata <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 32'h0;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ics_pkg::REG_TARGET: reg_rdata <= {25'h0, target};
        ics_pkg::REG_TXDATA: reg_rdata <= {24'h0, txdata};
        ics_pkg::REG_STATUS: reg_rdata <= {30'h0, nack, state != ics_pkg::H_IDLE};
        ics_pkg::REG_RXDATA: reg_rdata <= {24'h0, rxdata};
        default:             reg_rdata <= 32'h0;
      endcase
    end
    else
    begin
      reg_rdata <= 32'h0;
    end
  end

  // quarter-bit divider, 400 kHz at most
  always_ff @(posedge clock)
  begin
    if (sys_rst || state == ics_pkg::H_IDLE || tick)
    begin
      qcnt <= 7'h00;
    end
    else
    begin
      qcnt <= qcnt + 7'h01; // [R17]
    end
  end

  // transfer sequencer
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state      <= ics_pkg::H_IDLE;
      phase      <= 2'h0;
      slot       <= 4'h0;
      txsh       <= 8'h00;
      rxsh       <= 8'h00;
      rxdata     <= 8'h00;
      rw         <= 1'b0;
      recv       <= 1'b0;
      addr_phase <= 1'b0;
      left       <= 3'h0;
      nack       <= 1'b0;
      scl_rel    <= 1'b1;
      sda_rel    <= 1'b1;
    end
    else if (go)
    begin
      state <= ics_pkg::H_START;
      phase <= 2'h0;
      rw    <= reg_wdata[ics_pkg::CMD_READ_BIT];
      left  <= reg_wdata[ics_pkg::CMD_COUNT_LSB +: 3];
      nack  <= 1'b0;
    end
    else if (tick)
    begin
      phase <= phase + 2'h1;
      unique case (state)
        ics_pkg::H_IDLE:
        begin
        end
        ics_pkg::H_START:
        begin
          if (phase == 2'h1)
          begin
            sda_rel <= 1'b0;
          end
          else if (phase == 2'h2)
          begin
            scl_rel <= 1'b0;
          end
          else if (phase == 2'h3)
          begin
            state      <= ics_pkg::H_BYTE;
            slot       <= 4'h0;
            txsh       <= {target, rw}; // [R1] [R16]
            recv       <= 1'b0;
            addr_phase <= 1'b1;
          end
        end
        ics_pkg::H_BYTE:
        begin
          unique case (phase)
            2'h0: sda_rel <= slot != 4'h8 ? (recv || txsh[7]) : (!recv || left == 3'h0); // [R7]
            2'h1: scl_rel <= 1'b1;
            2'h2:
            begin
              if (slot != 4'h8)
              begin
                rxsh <= {rxsh[6:0], sda_sy[1]};
              end
              else if (!recv)
              begin
                nack <= sda_sy[1];
              end
            end
            2'h3:
            begin
              scl_rel <= 1'b0;
              if (slot != 4'h8)
              begin
                slot <= slot + 4'h1;
                txsh <= {txsh[6:0], 1'b0};
              end
              else
              begin
                slot       <= 4'h0;
                addr_phase <= 1'b0;
                if (!recv && nack)
                begin
                  state <= ics_pkg::H_STOP;
                end
                else if (recv)
                begin
                  rxdata <= rxsh;
                  left   <= left - 3'h1;
                  if (left == 3'h0)
                  begin
                    state <= ics_pkg::H_STOP; // [R7]
                  end
                end
                else if (addr_phase && rw)
                begin
                  recv <= 1'b1;
                end
                else if (addr_phase)
                begin
                  txsh <= txdata; // [R16]
                end
                else if (left == 3'h0)
                begin
                  state <= ics_pkg::H_STOP; // [R12]
                end
                else
                begin
                  left <= left - 3'h1;
                  txsh <= txdata;
                end
              end
            end
            default:
            begin
            end
          endcase
        end
        ics_pkg::H_STOP:
        begin
          if (phase == 2'h0)
          begin
            sda_rel <= 1'b0;
          end
          else if (phase == 2'h1)
          begin
            scl_rel <= 1'b1;
          end
          else if (phase == 2'h2)
          begin
            sda_rel <= 1'b1; // [R12]
          end
          else
          begin
            state <= ics_pkg::H_IDLE;
          end
        end
        default:
        begin
          state <= ics_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = !scl_rel;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = !sda_rel;
endmodule : ics_ctrl_host

// ---- verilog/ics_switch_dev.sv ----
`timescale 1ns/1ps
module ics_switch_dev (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       reset_pin_n,
  input  wire logic       por_below_threshold,
  input  wire logic       addr_sel_0,
  input  wire logic       addr_sel_1,
  input  wire logic       addr_sel_2,
  ics_link_if.device      link,
  output logic [7:0]      chan_enable,
  output logic [7:0]      chan_select
);
  logic [1:0]             scl_sy;
  logic [1:0]             sda_sy;
  logic [1:0]             rstn_sy;
  logic [1:0]             por_sy;
  logic [2:0]             strap_sy1;
  logic [2:0]             strap_sy2;
  logic                   scl_d;
  logic                   sda_d;
  logic [3:0]             rst_low_cnt;
  logic                   dev_rst;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_det;
  logic                   stop_det;
  logic [6:0]             own_addr;
  ics_pkg::ics_dev_state_t state;
  logic [3:0]             cnt;
  logic [7:0]             shreg;
  logic [7:0]             tx;
  logic                   rw;
  logic                   master_ack;
  logic                   sda_drive;
  logic                   byte_in_done;

  // two-stage synchronisers for pins
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      scl_sy    <= 2'h3;
      sda_sy    <= 2'h3;
      rstn_sy   <= 2'h3;
      por_sy    <= 2'h0;
      strap_sy1 <= 3'h0;
      strap_sy2 <= 3'h0;
    end
    else
    begin
      scl_sy    <= {scl_sy[0], link.scl};
      sda_sy    <= {sda_sy[0], link.sda};
      rstn_sy   <= {rstn_sy[0], reset_pin_n};
      por_sy    <= {por_sy[0], por_below_threshold};
      strap_sy1 <= {addr_sel_2, addr_sel_1, addr_sel_0};
      strap_sy2 <= strap_sy1;
    end
  end

  // previous line levels for edge and condition detection
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_sy[1];
      sda_d <= sda_sy[1];
    end
  end

  // reset pin must stay low for the minimum low time
  always_ff @(posedge clock)
  begin
    if (sys_rst || rstn_sy[1])
    begin
      rst_low_cnt <= 4'h0;
    end
    else if (rst_low_cnt != 4'hF)
    begin
      rst_low_cnt <= rst_low_cnt + 4'h1;
    end
  end

  assign dev_rst      = sys_rst || por_sy[1] || (rst_low_cnt >= 4'(ics_pkg::RESET_LOW_CYC)); // [R14] [R15]
  assign scl_rise     = scl_sy[1] && !scl_d;
  assign scl_fall     = !scl_sy[1] && scl_d;
  assign start_det    = scl_sy[1] && scl_d && sda_d && !sda_sy[1];
  assign stop_det     = scl_sy[1] && scl_d && !sda_d && sda_sy[1];
  assign own_addr     = ics_pkg::BASE_ADDR + {4'h0, strap_sy2}; // [R2]
  assign byte_in_done = scl_fall && (cnt == ics_pkg::BITS_PER_BYTE);

  // byte engine and data line drive
  always_ff @(posedge clock)
  begin
    if (dev_rst)
    begin
      state      <= ics_pkg::D_IDLE;
      cnt        <= 4'h0;
      shreg      <= 8'h00;
      tx         <= 8'h00;
      rw         <= 1'b0;
      master_ack <= 1'b0;
      sda_drive  <= 1'b0;
    end
    else if (start_det)
    begin
      state     <= ics_pkg::D_ADDR;
      cnt       <= 4'h0;
      sda_drive <= 1'b0;
    end
    else if (stop_det)
    begin
      state     <= ics_pkg::D_IDLE;
      sda_drive <= 1'b0;
    end
    else
    begin
      unique case (state)
        ics_pkg::D_IDLE:
        begin
        end
        ics_pkg::D_ADDR:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_sy[1]};
            cnt   <= cnt + 4'h1;
          end
          else if (byte_in_done)
          begin
            if (shreg[7:1] == own_addr) // [R2]
            begin
              state     <= ics_pkg::D_ACK_ADDR;
              sda_drive <= 1'b1; // [R3]
              rw        <= shreg[0]; // [R1]
            end
            else
            begin
              state <= ics_pkg::D_IDLE;
            end
          end
        end
        ics_pkg::D_ACK_ADDR:
        begin
          if (scl_fall)
          begin
            cnt <= 4'h0;
            if (rw)
            begin
              state     <= ics_pkg::D_READ;
              tx        <= chan_select; // [R6]
              sda_drive <= !chan_select[7];
            end
            else
            begin
              state     <= ics_pkg::D_WRITE;
              sda_drive <= 1'b0;
            end
          end
        end
        ics_pkg::D_WRITE:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_sy[1]};
            cnt   <= cnt + 4'h1;
          end
          else if (byte_in_done)
          begin
            state     <= ics_pkg::D_ACK_WR;
            sda_drive <= 1'b1; // [R5]
          end
        end
        ics_pkg::D_ACK_WR:
        begin
          if (scl_fall)
          begin
            state     <= ics_pkg::D_WRITE; // [R5]
            cnt       <= 4'h0;
            sda_drive <= 1'b0;
          end
        end
        ics_pkg::D_READ:
        begin
          if (scl_rise)
          begin
            cnt <= cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt == ics_pkg::BITS_PER_BYTE)
            begin
              state     <= ics_pkg::D_ACK_RD;
              sda_drive <= 1'b0;
            end
            else
            begin
              tx        <= {tx[6:0], 1'b0}; // [R6]
              sda_drive <= !tx[6];
            end
          end
        end
        ics_pkg::D_ACK_RD:
        begin
          if (scl_rise)
          begin
            master_ack <= !sda_sy[1];
          end
          else if (scl_fall)
          begin
            cnt <= 4'h0;
            if (master_ack)
            begin
              state     <= ics_pkg::D_READ;
              tx        <= chan_select; // [R18]
              sda_drive <= !chan_select[7];
            end
            else
            begin
              state     <= ics_pkg::D_IDLE; // [R8]
              sda_drive <= 1'b0;
            end
          end
        end
        default:
        begin
          state     <= ics_pkg::D_IDLE;
          sda_drive <= 1'b0;
        end
      endcase
    end
  end

  // every received data byte overwrites the register
  always_ff @(posedge clock)
  begin
    if (dev_rst)
    begin
      chan_select <= ics_pkg::CHAN_SEL_RESET; // [R13]
    end
    else if (state == ics_pkg::D_WRITE && byte_in_done && !start_det && !stop_det)
    begin
      chan_select <= shreg; // [R4] [R5] [R10]
    end
  end

  // switch enables follow the register only at stop
  always_ff @(posedge clock)
  begin
    if (dev_rst)
    begin
      chan_enable <= ics_pkg::CHAN_SEL_RESET; // [R13] [R14]
    end
    else if (stop_det)
    begin
      chan_enable <= chan_select; // [R9] [R11] [R19]
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = sda_drive;
endmodule : ics_switch_dev
